// File: design/dfs_pkg.sv
// Constants and carrier types for the disk format and status engine
package dfs_pkg;
   // Function codes
   localparam logic [7:0] FN_XSTAT = 8'h01;
   localparam logic [7:0] FN_FORMAT = 8'h02;
   // Track designation codes, format buffer byte 0
   localparam logic [7:0] DES_DATA = 8'h00;
   localparam logic [7:0] DES_ALT = 8'h40;
   localparam logic [7:0] DES_DEF = 8'h80;
   // Extended error code for a rejected designation
   localparam logic [7:0] XC_ILL_FMT = 8'h17;
   // Register byte offsets
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_WAKE = 6'h04;
   localparam logic [5:0] REG_FBUF0 = 6'h08;
   localparam logic [5:0] REG_FBUF1 = 6'h0c;
   localparam logic [5:0] REG_GEOM = 6'h10;
   localparam logic [5:0] REG_STAT = 6'h14;
   localparam logic [5:0] REG_XADDR = 6'h18;
   localparam logic [5:0] REG_TRACK = 6'h1c;
   localparam logic [5:0] REG_ALT = 6'h20;
   localparam logic [5:0] REG_IDFLG = 6'h24;
   localparam logic [5:0] REG_XCODE = 6'h28;
   // Field positions
   localparam int CTRL_START_BIT = 8;
   localparam int WAKE_XSTAT_BIT = 2;
   localparam int GEOM_SZ_LSB = 8;
   localparam int GEOM_FIXED_BIT = 16;
   localparam int HB_ILL_FMT = 6;
   localparam int SOFT_LSB = 3;
   // Reset values
   localparam logic [31:0] GEOM_RST = 32'h0001_0008;
   // Status transfer lengths
   localparam logic [3:0] STAT_LEN = 4'hc;
   localparam logic [3:0] STAT_LEN_X = 4'hd;
   // Sector framing
   localparam logic [10:0] ID_HDR_BYTES = 11'h004;
   localparam logic [10:0] SECT_BASE = 11'h080;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   // Track stream byte kinds
   localparam logic [1:0] K_ID = 2'h0;
   localparam logic [1:0] K_DATA = 2'h1;
   localparam logic [1:0] K_CHK = 2'h2;
   // Error lamp timing
   localparam longint CLK_PERIOD_NS = 8;
   localparam longint BLINK_NS = 64'd250_000_000;
   localparam int BLINK_CYC = int'(BLINK_NS / CLK_PERIOD_NS);
   localparam logic [3:0] GAP_TICKS = 4'h6;

   typedef struct packed {
      logic valid;
      logic [1:0] kind;
      logic [7:0] data;
   } dfs_trk_s;

   typedef struct packed {
      logic valid;
      logic [19:0] addr;
      logic [7:0] data;
   } dfs_mem_s;

   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic ok;
      logic [7:0] data;
   } dfs_rd_s;
endpackage

// File: design/dfs_engine.sv
// Disk track format, alternate redirect and status buffer engine
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module dfs_engine
   import dfs_pkg::*;
#(
   parameter int MAXS = 64,
   parameter int BLINK = BLINK_CYC
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [5:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   output dfs_trk_s o_trk,
   input wire logic i_trk_ready,
   input wire logic i_index,
   output dfs_mem_s o_mem,
   input wire logic i_mem_ready,
   input wire dfs_rd_s i_rd,
   input wire logic i_defect_acc,
   output logic o_alt_valid,
   output logic [15:0] o_alt_cyl,
   output logic [7:0] o_alt_head,
   input wire logic i_id_valid,
   input wire logic [7:0] i_id_flags,
   input wire logic [15:0] i_hard_evt,
   input wire logic [4:0] i_soft_evt,
   input wire logic i_alt_conflict,
   input wire logic i_xcode_valid,
   input wire logic [7:0] i_xcode,
   output logic o_error_indicator_led
);
   typedef enum {S_IDLE, S_CHECK, S_BUILD, S_WAITIDX, S_ID, S_DATA,
                 S_CHK, S_XFER} dfs_state_e;

   // Reduce a sum modulo the sector count
   function automatic logic [5:0] posmod(input logic [8:0] v,
                                         input logic [5:0] n);
      posmod = 6'(v % {3'h0, n});
   endfunction

   // One CRC step over a byte
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int k = 0; k < 8; k++) begin
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      crc_step = r;
   endfunction

   dfs_state_e state;
   logic [7:0] func;
   logic busy;
   logic ext_en;
   logic wake_seen;
   logic [47:0] fbuf;
   logic [31:0] geom;
   logic [31:0] xaddr;
   logic [23:0] track;
   logic [15:0] st_hard;
   logic [4:0] st_soft;
   logic [7:0] st_xcode;
   logic [7:0] st_sect;
   logic [7:0] id_flags;
   logic [5:0] imap [MAXS];
   logic [MAXS-1:0] used;
   logic [5:0] bpos;
   logic [6:0] bsec;
   logic [5:0] pidx;
   logic [10:0] bcnt;
   logic [15:0] crc;
   logic chk_dat;
   logic [3:0] xi;
   logic [23:0] alt_acc;
   logic [1:0] alt_cnt;
   logic alt_arm;
   logic [31:0] btick;
   logic [1:0] bph;
   logic [4:0] bleft;

   ////////////////////////////////////////////////////////////////////
   // Bus decode and field views
   wire req = i_read | i_write;
   wire acc = req & ~o_waitrequest;
   wire wr_hit = i_write & ~o_waitrequest;
   wire [7:0] des = fbuf[7:0];
   wire [31:0] pattern = fbuf[39:8];
   wire [7:0] ifac_raw = fbuf[47:40];
   wire [7:0] ifac = (ifac_raw == 8'h00) ? 8'h01 : ifac_raw;
   wire [5:0] nsect = geom[5:0];
   wire fixed_media = geom[GEOM_FIXED_BIT];
   wire [10:0] sect_len = SECT_BASE << geom[GEOM_SZ_LSB +: 2];
   wire des_known = (des == DES_DATA) | (des == DES_ALT) | (des == DES_DEF);
   wire des_ok = (des == DES_DATA) | (des_known & fixed_media);
   wire trk_adv = ~o_trk.valid | i_trk_ready;
   wire mem_adv = ~o_mem.valid | i_mem_ready;
   wire [5:0] cur_sect = imap[pidx];
   wire [3:0] st_len = ext_en ? STAT_LEN_X : STAT_LEN;
   wire [19:0] mem_base = {xaddr[31:16], 4'h0} + {4'h0, xaddr[15:0]};

   // Status buffer image; reserved bits forced low
   wire [7:0] st_b0 = {st_hard[7:3], 3'h0};
   wire [7:0] st_b1 = st_hard[15:8];
   wire [7:0] st_b2 = {st_soft, 3'h0};
   wire [103:0] st_img = {st_xcode, 8'h00, 32'h0, st_sect, track[7:0],
                          track[15:8], track[23:16], st_b2, st_b1,
                          st_b0};
   wire [7:0] st_byte = st_img[{xi, 3'h0} +: 8];

   // ID field bytes: cylinder, head, sector
   wire [7:0] id_byte = (bcnt == 11'h000) ? track[23:16] :
                        (bcnt == 11'h001) ? track[15:8] :
                        (bcnt == 11'h002) ? track[7:0] :
                        {2'h0, cur_sect};

   // Each data byte repeats the four-byte pattern in order
   wire [7:0] pat_byte = pattern[{bcnt[1:0], 3'h0} +: 8];

   // Register read selection
   wire [31:0] rd_mux =
      (i_address == REG_CTRL) ? {23'h0, busy, func} :
      (i_address == REG_WAKE) ? {29'h0, ext_en, 1'b0, wake_seen} :
      (i_address == REG_FBUF0) ? fbuf[31:0] :
      (i_address == REG_FBUF1) ? {16'h0, fbuf[47:32]} :
      (i_address == REG_GEOM) ? geom :
      (i_address == REG_STAT) ? {8'h0, st_b2, st_b1, st_b0} :
      (i_address == REG_XADDR) ? xaddr :
      (i_address == REG_TRACK) ? {8'h0, track} :
      (i_address == REG_ALT) ? {7'h0, o_alt_valid, o_alt_cyl, o_alt_head} :
      (i_address == REG_IDFLG) ? {24'h0, id_flags} :
      (i_address == REG_XCODE) ? {24'h0, st_xcode} : 32'h0;

   wire start_wr = wr_hit & (i_address == REG_CTRL)
                   & i_writedata[CTRL_START_BIT] & ~busy;

   ////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, then answer
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_waitrequest <= 1'b1;
         o_readdata <= 32'h0;
      end else begin
         o_waitrequest <= ~(req & o_waitrequest);
         if (req & o_waitrequest) begin
            o_readdata <= rd_mux;
         end
      end
   end

   // Configuration registers; frozen while a function runs
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fbuf <= 48'h0;
         geom <= GEOM_RST;
         xaddr <= 32'h0;
         track <= 24'h0;
      end else if (wr_hit & ~busy) begin
         if (i_address == REG_FBUF0) fbuf[31:0] <= i_writedata;
         if (i_address == REG_FBUF1) fbuf[47:32] <= i_writedata[15:0];
         if (i_address == REG_GEOM) geom <= i_writedata;
         if (i_address == REG_XADDR) xaddr <= i_writedata;
         if (i_address == REG_TRACK) track <= i_writedata[23:0];
      end
   end

   // Wake-up block: only the first write after reset counts
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wake_seen <= 1'b0;
         ext_en <= 1'b0;
      end else if (wr_hit & (i_address == REG_WAKE) & ~wake_seen) begin
         wake_seen <= 1'b1;
         ext_en <= i_writedata[WAKE_XSTAT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status buffer; events win over the clear at function start
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_hard <= 16'h0;
         st_soft <= 5'h0;
         st_xcode <= 8'h0;
      end else begin
         if (start_wr & (i_writedata[7:0] != FN_XSTAT)) begin
            st_hard <= i_hard_evt;
            st_soft <= i_soft_evt;
            st_xcode <= i_xcode_valid ? i_xcode : 8'h00;
         end else begin
            st_hard <= st_hard | i_hard_evt;
            st_soft <= st_soft | i_soft_evt;
            if (i_xcode_valid) st_xcode <= i_xcode;
         end
         if (i_alt_conflict) st_hard[HB_ILL_FMT] <= 1'b1;
         if ((state == S_CHECK) & ~des_ok) begin
            st_hard[HB_ILL_FMT] <= 1'b1;
            st_xcode <= XC_ILL_FMT;
         end
      end
   end

   // Read ID flag byte for alternate availability
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) id_flags <= 8'h0;
      else if (i_id_valid) id_flags <= i_id_flags;
   end

   ////////////////////////////////////////////////////////////////////
   // Function sequencer: format track and status transfer
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= S_IDLE;
         busy <= 1'b0;
         func <= 8'h0;
         used <= '0;
         bpos <= 6'h0;
         bsec <= 7'h0;
         pidx <= 6'h0;
         bcnt <= 11'h0;
         crc <= CRC_INIT;
         chk_dat <= 1'b0;
         xi <= 4'h0;
         st_sect <= 8'h0;
         o_trk <= '0;
         o_mem <= '0;
      end else begin
         if (i_trk_ready) o_trk.valid <= 1'b0;
         if (i_mem_ready) o_mem.valid <= 1'b0;
         unique case (state)
            S_IDLE: if (start_wr) begin
               func <= i_writedata[7:0];
               busy <= 1'b1;
               xi <= 4'h0;
               used <= '0;
               bpos <= 6'h0;
               bsec <= 7'h1;
               if (i_writedata[7:0] == FN_FORMAT) state <= S_CHECK;
               else if (i_writedata[7:0] == FN_XSTAT) state <= S_XFER;
               else busy <= 1'b0;
            end
            S_CHECK: if (des_ok) state <= S_BUILD;
            else begin
               busy <= 1'b0;
               state <= S_IDLE;
            end
            // Place sectors by stepping the interleave factor
            S_BUILD: if (bsec > {1'b0, nsect}) begin
               state <= S_WAITIDX;
               pidx <= 6'h0;
            end else if (used[bpos]) begin
               bpos <= posmod({3'h0, bpos} + 9'h001, nsect);
            end else begin
               imap[bpos] <= bsec[5:0];
               used[bpos] <= 1'b1;
               bsec <= bsec + 7'h1;
               bpos <= posmod({3'h0, bpos} + {1'b0, ifac}, nsect);
            end
            // Slot zero holds sector one, so it follows the index
            S_WAITIDX: if (i_index) begin
               state <= S_ID;
               bcnt <= 11'h0;
               crc <= CRC_INIT;
            end
            S_ID: if (trk_adv) begin
               o_trk <= '{valid: 1'b1, kind: K_ID, data: id_byte};
               crc <= crc_step(crc, id_byte);
               bcnt <= bcnt + 11'h1;
               if (bcnt == ID_HDR_BYTES - 11'h1) begin
                  state <= S_CHK;
                  bcnt <= 11'h0;
                  st_sect <= {2'h0, cur_sect};
               end
            end
            S_CHK: if (trk_adv) begin
               o_trk <= '{valid: 1'b1, kind: K_CHK,
                          data: bcnt[0] ? crc[7:0] : crc[15:8]};
               bcnt <= bcnt + 11'h1;
               if (bcnt[0]) begin
                  bcnt <= 11'h0;
                  crc <= CRC_INIT;
                  chk_dat <= 1'b0;
                  // Header check leads to data; data check ends the slot
                  if (!chk_dat) begin
                     state <= S_DATA;
                  end else if (pidx == nsect - 6'h1) begin
                     state <= S_IDLE;
                     busy <= 1'b0;
                  end else begin
                     pidx <= pidx + 6'h1;
                     state <= S_ID;
                  end
               end
            end
            S_DATA: if (trk_adv) begin
               o_trk <= '{valid: 1'b1, kind: K_DATA, data: pat_byte};
               crc <= crc_step(crc, pat_byte);
               bcnt <= bcnt + 11'h1;
               if (bcnt == sect_len - 11'h1) begin
                  state <= S_CHK;
                  chk_dat <= 1'b1;
                  bcnt <= 11'h0;
               end
            end
            S_XFER: if (mem_adv) begin
               o_mem <= '{valid: 1'b1, addr: mem_base + {16'h0, xi},
                          data: st_byte};
               xi <= xi + 4'h1;
               if (xi == st_len - 4'h1) begin
                  state <= S_IDLE;
                  busy <= 1'b0;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Alternate address capture from the first good data field after a defect access
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         alt_arm <= 1'b0;
         alt_cnt <= 2'h0;
         alt_acc <= 24'h0;
         o_alt_valid <= 1'b0;
         o_alt_cyl <= 16'h0;
         o_alt_head <= 8'h0;
      end else begin
         if (i_defect_acc) begin
            alt_arm <= 1'b1;
            o_alt_valid <= 1'b0;
         end else if (alt_arm & i_rd.valid) begin
            if (i_rd.sof) alt_cnt <= 2'h1;
            else if (alt_cnt != 2'h3) alt_cnt <= alt_cnt + 2'h1;
            if (i_rd.sof) alt_acc[23:16] <= i_rd.data;
            else if (alt_cnt == 2'h1) alt_acc[15:8] <= i_rd.data;
            else if (alt_cnt == 2'h2) alt_acc[7:0] <= i_rd.data;
            // A bad field is skipped; the next good one is used
            if (i_rd.eof & i_rd.ok & (alt_cnt == 2'h3)) begin
               alt_arm <= 1'b0;
               o_alt_valid <= 1'b1;
               o_alt_cyl <= alt_acc[23:8];
               o_alt_head <= alt_acc[7:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Lamp blinks the high digit, the low digit, then a pause
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         btick <= 32'h0;
         bph <= 2'h0;
         bleft <= 5'h0;
         o_error_indicator_led <= 1'b0;
      end else if (btick != 32'h0) begin
         btick <= btick - 32'h1;
      end else begin
         btick <= 32'(BLINK - 1);
         if (bleft != 5'h0) begin
            bleft <= bleft - 5'h1;
            o_error_indicator_led <= (bph != 2'h2) & ~o_error_indicator_led;
         end else begin
            o_error_indicator_led <= 1'b0;
            bph <= (bph == 2'h2) ? 2'h0 : bph + 2'h1;
            unique case (bph)
               2'h0: bleft <= {st_xcode[3:0], 1'b0};
               2'h1: bleft <= {1'b0, GAP_TICKS};
               default: bleft <= {st_xcode[7:4], 1'b0};
            endcase
         end
      end
   end
endmodule

// File: dv/dfs_chk.sv
// Port-level checks for the format and status engine
`timescale 1ns/1ps
module dfs_chk
   import dfs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic o_waitrequest,
   input wire dfs_trk_s o_trk,
   input wire logic i_trk_ready,
   input wire dfs_mem_s o_mem,
   input wire logic i_mem_ready,
   input wire dfs_rd_s i_rd,
   input wire logic o_alt_valid
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic chk_odd;
   wire trk_tk = o_trk.valid && i_trk_ready;
   ////////////////////////////////////////////////////////////////////////////
   // Check bytes travel in pairs; an odd count shows a lost byte
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         chk_odd <= 1'b0;
      end else if (trk_tk && o_trk.kind == K_CHK) begin
         chk_odd <= !chk_odd;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_wr_pulse;
      !o_waitrequest |=> o_waitrequest;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("waitrequest low two cycles");
   property p_wr_cause;
      !o_waitrequest |-> $past(i_read || i_write);
   endproperty
   a_wr_cause: assert property (p_wr_cause)
      else $error("answer without request");
   property p_trk_hold;
      o_trk.valid && !i_trk_ready |=> $stable(o_trk);
   endproperty
   a_trk_hold: assert property (p_trk_hold)
      else $error("track byte changed while stalled");
   property p_trk_kind;
      o_trk.valid |-> o_trk.kind != 2'h3;
   endproperty
   a_trk_kind: assert property (p_trk_kind)
      else $error("undefined track byte kind");
   property p_chk_pair;
      trk_tk && o_trk.kind != K_CHK |-> !chk_odd;
   endproperty
   a_chk_pair: assert property (p_chk_pair)
      else $error("check bytes not paired");
   property p_mem_hold;
      o_mem.valid && !i_mem_ready |=> $stable(o_mem);
   endproperty
   a_mem_hold: assert property (p_mem_hold)
      else $error("status byte changed while stalled");
   property p_mem_seq;
      o_mem.valid && i_mem_ready ##1 o_mem.valid
         |-> o_mem.addr == $past(o_mem.addr) + 20'h1;
   endproperty
   a_mem_seq: assert property (p_mem_seq)
      else $error("status address not consecutive");
   property p_alt_cause;
      $rose(o_alt_valid) |-> $past(i_rd.valid && i_rd.eof && i_rd.ok);
   endproperty
   a_alt_cause: assert property (p_alt_cause)
      else $error("alternate without good field end");
   // Main scenarios reached
   c_data: cover property (trk_tk && o_trk.kind == K_DATA);
   c_mem: cover property (o_mem.valid && i_mem_ready);
   c_alt: cover property ($rose(o_alt_valid));
endmodule
bind dfs_engine dfs_chk dfs_chk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_read(i_read), .i_write(i_write), .o_waitrequest(o_waitrequest),
   .o_trk(o_trk), .i_trk_ready(i_trk_ready), .o_mem(o_mem),
   .i_mem_ready(i_mem_ready), .i_rd(i_rd), .o_alt_valid(o_alt_valid));

// File: dv/dfs_host_model.sv
// Host memory and track sink that may stall either stream
`timescale 1ns/1ps
module dfs_host_model
   import dfs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_slow,
   input wire dfs_trk_s i_trk,
   output logic o_trk_ready,
   input wire dfs_mem_s i_mem,
   output logic o_mem_ready
);
   logic [7:0] mem [logic [19:0]];
   logic [7:0] trk_d [$];
   logic [1:0] trk_k [$];
   int n_mem = 0;
   // Random stalls make the engine hold a byte while ready is low
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_trk_ready <= 1'b0;
         o_mem_ready <= 1'b0;
      end else begin
         if (i_trk.valid && o_trk_ready) begin
            trk_d.push_back(i_trk.data);
            trk_k.push_back(i_trk.kind);
         end
         if (i_mem.valid && o_mem_ready) begin
            mem[i_mem.addr] = i_mem.data;
            n_mem++;
         end
         o_trk_ready <= !i_slow || ($urandom_range(3) != 0);
         o_mem_ready <= !i_slow || ($urandom_range(2) != 0);
      end
   end
endmodule

// File: dv/disk_format_and_status_bench.sv
// Self-checking bench for the format and status engine
`timescale 1ns/1ps
module disk_format_and_status_bench
   import dfs_pkg::*;
;
   logic i_clk, i_sys_rst, i_read, i_write, i_index, i_defect_acc, slow;
   logic i_id_valid, i_alt_conflict, o_waitrequest, o_alt_valid, led;
   logic trk_rdy, mem_rdy;
   logic [5:0] i_address;
   logic [31:0] i_writedata, o_readdata, q;
   logic [7:0] i_id_flags, o_alt_head;
   logic [15:0] i_hard_evt, o_alt_cyl;
   logic [4:0] i_soft_evt;
   dfs_trk_s o_trk;
   dfs_mem_s o_mem;
   dfs_rd_s i_rd;
   int n_mismatch, tests_run, idx_cnt;
   // Physical order from index for factors 1 to 4, one digit a slot
   logic [31:0] ord [4] = '{32'h12345678, 32'h15263748, 32'h14725836,
      32'h13572468};
   dfs_engine #(.BLINK(4)) dfs_engine_i (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_address(i_address), .i_read(i_read),
      .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .o_trk(o_trk), .i_trk_ready(trk_rdy),
      .i_index(i_index), .o_mem(o_mem), .i_mem_ready(mem_rdy), .i_rd(i_rd),
      .i_defect_acc(i_defect_acc), .o_alt_valid(o_alt_valid),
      .o_alt_cyl(o_alt_cyl), .o_alt_head(o_alt_head),
      .i_id_valid(i_id_valid), .i_id_flags(i_id_flags),
      .i_hard_evt(i_hard_evt), .i_soft_evt(i_soft_evt),
      .i_alt_conflict(i_alt_conflict), .i_xcode_valid(1'b0),
      .i_xcode(8'h00), .o_error_indicator_led(led));
   dfs_host_model dfs_host_model_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_slow(slow), .i_trk(o_trk), .o_trk_ready(trk_rdy), .i_mem(o_mem),
      .o_mem_ready(mem_rdy));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // Index mark free-runs, so format waits a varying time
   always @(posedge i_clk) begin
      idx_cnt <= idx_cnt + 1;
      i_index <= (idx_cnt % 64 == 0);
   end
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is sampled low
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      i_address <= a;
      i_writedata <= d;
      i_read <= !w;
      i_write <= w;
      n = 0;
      // Look mid-cycle, then act at the edge that samples the answer
      do begin
         @(negedge i_clk);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 200);
      q = o_readdata;
      @(posedge i_clk);
      i_read <= 1'b0;
      i_write <= 1'b0;
      if (n >= 200) n_mismatch++;
   endtask
   task run_fn(input logic [7:0] f);
      int n;
      bus(1'b1, REG_CTRL, {23'h0, 1'b1, f});
      n = 0;
      do begin
         bus(1'b0, REG_CTRL, 32'h0);
         n++;
      end while (q[CTRL_START_BIT] !== 1'b0 && n < 3000);
      if (n >= 3000) n_mismatch++;
      // Last byte may still wait for the sink after busy drops
      while (o_trk.valid || o_mem.valid) @(posedge i_clk);
   endtask
   // Format one track and compare the kind of every byte and the value of each ID and data byte, except pattern byte 3 on a DES_DEF track
   task fmt(input logic [7:0] des, input int fac, input logic [31:0] pat,
      input bit good);
      int o, en;
      logic [23:0] trk;
      logic [31:0] id;
      logic [7:0] ed, dm;
      logic [1:0] ek;
      trk = $urandom;
      dfs_host_model_i.trk_d.delete();
      dfs_host_model_i.trk_k.delete();
      bus(1'b1, REG_TRACK, {8'h0, trk});
      bus(1'b1, REG_FBUF0, {pat[23:0], des});
      bus(1'b1, REG_FBUF1, {16'h0, 8'(fac), pat[31:24]});
      run_fn(FN_FORMAT);
      en = good ? 8 * 136 : 0;
      chk(dfs_host_model_i.trk_d.size(), en);
      for (int i = 0; i < en; i++) begin
         o = i % 136;
         id = {trk, 4'h0, ord[fac - 1][31 - 4 * (i / 136) -: 4]};
         ek = (o < 4) ? K_ID : (o < 6 || o >= 134) ? K_CHK : K_DATA;
         ed = (o < 4) ? id[31 - 8 * o -: 8] : pat[8 * ((o - 6) % 4) +: 8];
         dm = (ek == K_CHK || (des == DES_DEF && (o - 6) % 4 == 3)) ?
            8'h00 : 8'hff;
         chk({dfs_host_model_i.trk_k[i], dfs_host_model_i.trk_d[i] & dm},
            {ek, ed & dm});
      end
      $display("test format %h factor %0d done", des, fac);
   endtask
   // Raise events, read them back, copy status to host memory
   task stat_run(input int len);
      logic [15:0] h;
      logic [4:0] s5;
      logic [23:0] ex;
      logic [31:0] ad;
      logic [19:0] base;
      int n0;
      h = $urandom;
      s5 = $urandom;
      ad = $urandom;
      @(posedge i_clk);
      i_hard_evt <= h;
      i_soft_evt <= s5;
      i_alt_conflict <= 1'b1;
      i_id_valid <= 1'b1;
      i_id_flags <= h[7:0];
      @(posedge i_clk);
      i_hard_evt <= 16'h0;
      i_soft_evt <= 5'h0;
      i_alt_conflict <= 1'b0;
      i_id_valid <= 1'b0;
      ex = {s5, 3'h0, h[15:8], h[7], 1'b1, h[5:3], 3'h0};
      bus(1'b0, REG_STAT, 32'h0);
      chk(q[23:0], ex);
      bus(1'b0, REG_IDFLG, 32'h0);
      chk(q[7:0], h[7:0]);
      bus(1'b1, REG_XADDR, ad);
      base = {ad[31:16], 4'h0} + {4'h0, ad[15:0]};
      n0 = dfs_host_model_i.n_mem;
      run_fn(FN_XSTAT);
      chk(dfs_host_model_i.n_mem - n0, len);
      for (int i = 0; i < 3; i++) begin
         chk(dfs_host_model_i.mem[base + 20'(i)], ex[8 * i +: 8]);
      end
      if (len == 13) begin
         chk(dfs_host_model_i.mem[base + 20'hc], XC_ILL_FMT);
      end
      run_fn(8'h03);
      bus(1'b0, REG_STAT, 32'h0);
      chk(q[23:0], 24'h0);
      $display("test status length %0d done", len);
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (80000) @(posedge i_clk);
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      logic [31:0] ab;
      {i_sys_rst, i_read, i_write, i_defect_acc, slow} = 5'h10;
      {i_id_valid, i_alt_conflict, i_address, i_writedata} = '0;
      {i_id_flags, i_hard_evt, i_soft_evt, i_rd, idx_cnt} = '0;
      n_mismatch = 0;
      tests_run = 0;
      void'($urandom(5616));
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      bus(1'b0, REG_GEOM, 32'h0);
      chk(q, GEOM_RST);
      bus(1'b0, 6'h3c, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, REG_WAKE, 32'h0);
      bus(1'b1, REG_WAKE, 32'h4);
      slow <= 1'b1;
      stat_run(12);
      for (int f = 1; f <= 4; f++) fmt(DES_DATA, f, $urandom, 1);
      fmt(DES_ALT, 2, $urandom, 1);
      fmt(DES_DEF, 1, {8'h0, 24'($urandom)}, 1);
      bus(1'b1, REG_GEOM, 32'h0000_0008);
      fmt(DES_ALT, 1, $urandom, 0);
      bus(1'b1, REG_GEOM, GEOM_RST);
      // Defective track access: alternate taken from a good field
      ab = $urandom;
      @(posedge i_clk);
      i_defect_acc <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk);
         i_defect_acc <= 1'b0;
         i_rd <= '{1'b1, i == 0, i == 3, 1'b1, ab[8 * i +: 8]};
      end
      @(posedge i_clk);
      i_rd <= '0;
      @(posedge i_clk);
      chk({o_alt_cyl, o_alt_head, 7'h0, o_alt_valid},
         {ab[7:0], ab[15:8], ab[23:16], 8'h01});
      $display("test redirect done");
      // Second reset in mid-run, this time with extended status
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      bus(1'b1, REG_WAKE, 32'h4);
      fmt(8'h20, 1, $urandom, 0);
      bus(1'b0, REG_STAT, 32'h0);
      chk(q[HB_ILL_FMT], 1'b1);
      bus(1'b0, REG_XCODE, 32'h0);
      chk(q[7:0], XC_ILL_FMT);
      stat_run(13);
      tally_and_finish;
   end
endmodule
